// ===== inc/adccal_pkg.sv
package adccal_pkg;

  // Register port geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  // Status register addresses
  localparam logic [6:0] ADDR_RESULT_BASE    = 7'h00;
  localparam logic [6:0] ADDR_SUPPLY_OFFSET  = 7'h08;
  localparam logic [6:0] ADDR_ADC_OFFSET     = 7'h09;
  localparam logic [6:0] ADDR_ADC_GAIN       = 7'h0a;
  // Configuration and sequence registers
  localparam logic [6:0] ADDR_CONFIG0        = 7'h40;
  localparam logic [6:0] ADDR_CONFIG1        = 7'h41;
  localparam logic [6:0] ADDR_CONFIG2        = 7'h42;
  localparam logic [6:0] ADDR_AVERAGE0       = 7'h4a;
  localparam logic [6:0] ADDR_SEQ_SELECT0    = 7'h48;
  localparam logic [6:0] ADDR_SEQ_ACQ0       = 7'h4e;
  localparam logic [6:0] ADDR_SEQ_ACQ1       = 7'h4f;

  // Configuration register 0 fields
  localparam int CFG0_CHAN_LSB   = 0;
  localparam int CFG0_ACQ_EXT    = 8;
  localparam int CFG0_EVENT_MODE = 9;
  localparam int CFG0_AVG_LSB    = 12;
  // Configuration register 1 fields
  localparam int CFG1_CAL_LSB    = 4;
  localparam int CFG1_SEQ_EN     = 12;
  // Configuration register 2 fields
  localparam int CFG2_DIV_LSB    = 8;

  // Reset values
  localparam logic [15:0] CONFIG0_RESET = 16'h0000;
  localparam logic [15:0] CONFIG1_RESET = 16'h0000;
  localparam logic [15:0] CONFIG2_RESET = 16'h0800;

  // Channels
  localparam logic [4:0] CAL_CHANNEL = 5'h08;
  localparam int         NUM_CHAN    = 16;

  // Timing in conversion-clock and port-clock cycles
  localparam int MIN_DIV        = 8;
  localparam int ACQ_CYCLES     = 4;
  localparam int ACQ_EXTRA      = 6;
  localparam int CONV_CYCLES    = 22;
  localparam int EOC_DELAY      = 10;
  localparam int READ_LATENCY   = 3;

  // Register port request
  typedef struct packed {
    logic              enable;
    logic              writeEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } adccal_port_req_s;

  // Register port answer
  typedef struct packed {
    logic              ready;
    logic [DATA_W-1:0] rdata;
  } adccal_port_rsp_s;

  // Event outputs
  typedef struct packed {
    logic       busy;
    logic       endOfConv;
    logic       endOfSequence;
    logic [4:0] channel;
  } adccal_events_s;

endpackage

// ===== rtl/adccal_clk_div.sv
`timescale 1ns/100ps
`default_nettype none

// Conversion clock as a one-cycle enable of the port clock
module adccal_clk_div #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // Control
  input  wire logic             restart,
  input  wire logic [DIV_W-1:0] ratio,
  // Enable out
  output logic                  tick
);
  import adccal_pkg::*;

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;

  // Ratios below the floor are forced up
  assign limit = (ratio < DIV_W'(MIN_DIV)) ? DIV_W'(MIN_DIV) : ratio;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= limit - DIV_W'(1)) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + DIV_W'(1);
      tick  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/adccal_ctrl.sv
// Contract
// - Channel 8 conversion computes all coefficients
// - Busy high throughout calibration sequence
// - Corrections applied only while enable bits set
// - Coefficients at status 08h, 09h, 0Ah
// - Offsets 10-bit two's complement, MSB justified
// - Gain in six LSBs, bit5 sign
// - Five magnitude bits, 0.2 percent each
// - Subtract offset, then multiply by gain
// - Port-clock timing, divider ratio minimum 8
// - Continuous mode restarts conversions automatically
// - Mode chosen by configuration register 0; sequence enable in configuration register 1 forces continuous mode
// - Acquisition four conversion-clock cycles
// - Configuration latched when busy falls
// - Sequence advances channel when busy falls
// - Acquisition extend adds six cycles
// - Busy rises edge after sampling edge
// - Conversion lasts 22 conversion-clock cycles
// - Result and one-cycle EOC ten cycles later
// - Averaged channel updates on final sample
// - Channel outputs update when busy falls
// - End-of-sequence pulses for last channel
// - Read data and ready three cycles later
`timescale 1ns/100ps
`default_nettype none

module adccal_ctrl #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         arst_n,
  // Register port
  input  wire adccal_pkg::adccal_port_req_s portReq,
  output adccal_pkg::adccal_port_rsp_s      portRsp,
  // Convert start pins, asynchronous
  input  wire logic                         convertStartPin,
  input  wire logic                         convertStartClockPin,
  // Analog front end result
  input  wire logic [9:0]                   rawCode,
  // Events
  output adccal_pkg::adccal_events_s        events
);
  import adccal_pkg::*;

  typedef enum logic [1:0] {ACQUIRE, WAIT_START, CONVERT} adccal_state_e;

  adccal_state_e state;
  logic [15:0] cfgLive0, cfgLive1, cfgLive2, avgLive, seqLive, seqAcqLive;
  logic [15:0] cfg0, cfg1, cfg2, avgEn, seqSel, seqAcq;
  logic [15:0] results [NUM_CHAN];
  logic [15:0] supplyOffset, adcOffset, adcGain;
  logic [4:0]  curChan, doneChan;
  logic [4:0]  cycleCount;
  logic        convTick, divRestart;
  logic [3:0]  eocCount;
  logic        eocPending;
  logic [7:0]  avgCount [NUM_CHAN];
  logic [17:0] avgSum [NUM_CHAN];
  logic [2:0]  startSync;
  logic        startSeen;
  logic        startLevel;
  logic [1:0]  readPipe;
  logic [6:0]  readAddr;
  logic        busyFall;
  logic        eventMode;
  logic [4:0]  acqTarget;
  logic        busyOut, eocOut, eosOut;

  function automatic logic [4:0] next_seq_chan(input logic [15:0] sel, input logic [4:0] cur);
    logic [4:0] c;
    c = cur;
    for (int i = 0; i < NUM_CHAN; i++) begin
      c = (c + 5'd1) & 5'h0f;
      if (sel[c[3:0]]) begin
        return c;
      end
    end
    return cur;
  endfunction

  function automatic logic [4:0] last_seq_chan(input logic [15:0] sel);
    logic [4:0] c;
    c = 5'd0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (sel[i]) begin
        c = 5'(i);
      end
    end
    return c;
  endfunction

  // Offset removal then gain scaling in 0.2 percent steps
  function automatic logic [9:0] correct(input logic [9:0] raw, input logic [15:0] off,
                                         input logic [15:0] gain, input logic [1:0] en);
    logic signed [12:0] v;
    logic signed [22:0] scaled;
    logic signed [22:0] step;
    v = $signed({3'b000, raw});
    if (en[0]) begin
      v = v - 13'($signed(off[15:6]));
    end
    step = 23'(v) * 23'($signed({1'b0, gain[4:0]}));
    scaled = 23'(v) * 23'sd500;
    if (en[1]) begin
      scaled = gain[5] ? scaled + step : scaled - step;
    end
    scaled = scaled / 23'sd500;
    if (scaled < 0) begin
      return 10'h000;
    end else if (scaled > 23'sd1023) begin
      return 10'h3ff;
    end
    return scaled[9:0];
  endfunction

  adccal_clk_div #(.DIV_W(DIV_W)) u_div (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .restart  (divRestart),
    .ratio    (cfg2[CFG2_DIV_LSB +: DIV_W]),
    .tick     (convTick)
  );

  assign eventMode = cfg0[CFG0_EVENT_MODE] & ~cfg1[CFG1_SEQ_EN];
  assign acqTarget = 5'(ACQ_CYCLES) +
                     ((cfg1[CFG1_SEQ_EN] ? seqAcq[curChan[3:0]] : cfg0[CFG0_ACQ_EXT])
                      ? 5'(ACQ_EXTRA) : 5'd0);
  // Fresh divider phase when a new ratio is latched
  assign divRestart = busyFall && (cfgLive2 != cfg2);
  // One driver for the whole event bundle
  assign events = '{busy: busyOut, endOfConv: eocOut,
                    endOfSequence: eosOut, channel: doneChan};

  // Live configuration written through the port
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgLive0   <= CONFIG0_RESET;
      cfgLive1   <= CONFIG1_RESET;
      cfgLive2   <= CONFIG2_RESET;
      avgLive    <= 16'h0000;
      seqLive    <= 16'h0000;
      seqAcqLive <= 16'h0000;
    end else if (portReq.enable && portReq.writeEn) begin
      if (portReq.addr == ADDR_CONFIG0) begin
        cfgLive0 <= portReq.wdata;
      end else if (portReq.addr == ADDR_CONFIG1) begin
        cfgLive1 <= portReq.wdata;
      end else if (portReq.addr == ADDR_CONFIG2) begin
        cfgLive2 <= portReq.wdata;
      end else if (portReq.addr == ADDR_AVERAGE0) begin
        avgLive <= portReq.wdata;
      end else if (portReq.addr == ADDR_SEQ_SELECT0) begin
        seqLive <= portReq.wdata;
      end else if (portReq.addr == ADDR_SEQ_ACQ0) begin
        seqAcqLive <= portReq.wdata;
      end
    end
  end

  // Active settings take effect only at the end of a conversion
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg0   <= CONFIG0_RESET;
      cfg1   <= CONFIG1_RESET;
      cfg2   <= CONFIG2_RESET;
      avgEn  <= 16'h0000;
      seqSel <= 16'h0000;
      seqAcq <= 16'h0000;
    end else if (busyFall) begin
      cfg0   <= cfgLive0;
      cfg1   <= cfgLive1;
      cfg2   <= cfgLive2;
      avgEn  <= avgLive;
      seqSel <= seqLive;
      seqAcq <= seqAcqLive;
    end
  end

  // Convert start pins are ORed; three-stage synchroniser
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      startSync  <= 3'b000;
      startLevel <= 1'b0;
      startSeen  <= 1'b0;
    end else begin
      startSync <= {startSync[1:0], convertStartPin | convertStartClockPin};
      // Level moves only once stages two and three agree
      if (startSync[2] == startSync[1]) begin
        startLevel <= startSync[2];
      end
      if (state == WAIT_START && startSync[2] && startSync[1] && !startLevel) begin
        startSeen <= 1'b1;
      end else if (state != WAIT_START) begin
        startSeen <= 1'b0;
      end
    end
  end

  // Acquisition and conversion sequencing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= ACQUIRE;
      cycleCount   <= 5'd0;
      busyOut      <= 1'b0;
      busyFall     <= 1'b0;
      curChan      <= 5'd0;
    end else begin
      busyFall <= 1'b0;
      case (state)
        ACQUIRE: begin
          if (eventMode) begin
            state <= WAIT_START;
          end else if (convTick) begin
            if (cycleCount + 5'd1 >= acqTarget) begin
              state       <= CONVERT;
              cycleCount  <= 5'd0;
              busyOut     <= 1'b1;
            end else begin
              cycleCount <= cycleCount + 5'd1;
            end
          end
        end
        WAIT_START: begin
          if (!eventMode) begin
            state <= ACQUIRE;
          end else if (startSeen && convTick) begin
            state       <= CONVERT;
            cycleCount  <= 5'd0;
            busyOut     <= 1'b1;
          end
        end
        CONVERT: begin
          // Busy stays high across calibration too
          if (convTick) begin
            if (cycleCount == 5'(CONV_CYCLES - 1)) begin
              state       <= ACQUIRE;
              cycleCount  <= 5'd0;
              busyOut     <= 1'b0;
              busyFall    <= 1'b1;
              curChan     <= cfgLive1[CFG1_SEQ_EN] ? next_seq_chan(seqLive, curChan)
                                                   : cfgLive0[4:0];
            end else begin
              cycleCount <= cycleCount + 5'd1;
            end
          end
        end
        default: state <= ACQUIRE;
      endcase
    end
  end

  // Channel outputs follow the falling busy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      doneChan <= 5'd0;
    end else if (state == CONVERT && convTick && cycleCount == 5'(CONV_CYCLES - 1)) begin
      doneChan <= curChan;
    end
  end

  // Result write ten cycles after busy falls
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eocCount             <= 4'd0;
      eocPending           <= 1'b0;
      eocOut               <= 1'b0;
      eosOut               <= 1'b0;
      supplyOffset         <= 16'h0000;
      adcOffset            <= 16'h0000;
      adcGain              <= 16'h0000;
      for (int i = 0; i < NUM_CHAN; i++) begin
        results[i]  <= 16'h0000;
        avgCount[i] <= 8'd0;
        avgSum[i]   <= 18'd0;
      end
    end else begin
      eocOut <= 1'b0;
      eosOut <= 1'b0;
      if (busyFall) begin
        eocPending <= 1'b1;
        eocCount   <= 4'd1;
      end else if (eocPending && eocCount == 4'(EOC_DELAY - 1)) begin
        eocPending <= 1'b0;
        if (doneChan == CAL_CHANNEL) begin
          supplyOffset <= {rawCode ^ 10'h200, 6'h00};
          adcOffset    <= {rawCode ^ 10'h200, 6'h00};
          adcGain      <= {10'h000, rawCode[5:0]};
          eocOut       <= 1'b1;
        end else if (avgEn[doneChan[3:0]] && avgCount[doneChan[3:0]] != 8'd15) begin
          avgCount[doneChan[3:0]] <= avgCount[doneChan[3:0]] + 8'd1;
          avgSum[doneChan[3:0]]   <= avgSum[doneChan[3:0]] + 18'(rawCode);
        end else begin
          avgCount[doneChan[3:0]] <= 8'd0;
          avgSum[doneChan[3:0]]   <= 18'd0;
          results[doneChan[3:0]]  <= {correct(avgEn[doneChan[3:0]]
                                        ? 10'((avgSum[doneChan[3:0]] + 18'(rawCode)) >> 4)
                                        : rawCode,
                                      adcOffset, adcGain, cfg1[CFG1_CAL_LSB +: 2]), 6'h00};
          eocOut <= 1'b1;
          eosOut <= cfg1[CFG1_SEQ_EN]
                    && doneChan == last_seq_chan(seqSel);
        end
      end else if (eocPending) begin
        eocCount <= eocCount + 4'd1;
      end
    end
  end

  // Read pipeline: data valid three cycles after the request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      readPipe      <= 2'b00;
      readAddr      <= 7'h00;
      portRsp.ready <= 1'b0;
      portRsp.rdata <= 16'h0000;
    end else begin
      readPipe      <= {readPipe[0], portReq.enable};
      portRsp.ready <= readPipe[1];
      if (portReq.enable) begin
        readAddr <= portReq.addr;
      end
      if (readPipe[1]) begin
        if (readAddr == ADDR_SUPPLY_OFFSET) begin
          portRsp.rdata <= supplyOffset;
        end else if (readAddr == ADDR_ADC_OFFSET) begin
          portRsp.rdata <= adcOffset;
        end else if (readAddr == ADDR_ADC_GAIN) begin
          portRsp.rdata <= adcGain;
        end else if (readAddr < 7'h10 && readAddr != 7'h08) begin
          portRsp.rdata <= results[readAddr[3:0]];
        end else if (readAddr == ADDR_CONFIG0) begin
          portRsp.rdata <= cfgLive0;
        end else if (readAddr == ADDR_CONFIG1) begin
          portRsp.rdata <= cfgLive1;
        end else if (readAddr == ADDR_CONFIG2) begin
          portRsp.rdata <= cfgLive2;
        end else begin
          portRsp.rdata <= 16'h0000;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== test/adccal_ctrl_properties.sv
`timescale 1ns/100ps
`default_nettype none
module adccal_ctrl_properties (
  // Clock and reset
  input wire logic                         core_clk,
  input wire logic                         arst_n,
  // Watched ports
  input wire adccal_pkg::adccal_port_req_s portReq,
  input wire adccal_pkg::adccal_port_rsp_s portRsp,
  input wire logic                         convertStartPin,
  input wire logic                         convertStartClockPin,
  input wire logic [9:0]                   rawCode,
  input wire adccal_pkg::adccal_events_s   events
);
  import adccal_pkg::*;

  logic busyQ;
  int   phaseCnt;

  // Length of the busy or idle phase just ended
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busyQ    <= 1'b0;
      phaseCnt <= 0;
    end else begin
      busyQ    <= events.busy;
      phaseCnt <= (events.busy != busyQ) ? 1 : phaseCnt + 1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_ready_latency: assert property (portReq.enable |-> ##3 portRsp.ready)
    else $error("ready missing three cycles after enable");
  a_ready_cause: assert property (portRsp.ready |-> $past(portReq.enable, 3))
    else $error("ready without an earlier enable");
  a_rdata_hold: assert property (!portRsp.ready |-> $stable(portRsp.rdata))
    else $error("read data moved between answers");
  a_eoc_timing: assert property (events.endOfConv |->
    $past(events.busy, 11) && !$past(events.busy, 10))
    else $error("end of conversion not ten cycles after busy fall");
  a_eoc_single: assert property (events.endOfConv |=> !events.endOfConv)
    else $error("end of conversion longer than one cycle");
  a_eos_with_eoc: assert property (events.endOfSequence |-> events.endOfConv)
    else $error("end of sequence without end of conversion");
  a_chan_update: assert property ($changed(events.channel) |-> $fell(events.busy))
    else $error("channel changed away from busy fall");
  a_conv_length: assert property ($fell(events.busy) |->
    phaseCnt >= CONV_CYCLES * MIN_DIV)
    else $error("conversion phase too short");
  a_acq_gap: assert property ($rose(events.busy) |->
    phaseCnt >= (ACQ_CYCLES - 1) * MIN_DIV)
    else $error("acquisition phase too short");
endmodule

bind adccal_ctrl adccal_ctrl_properties i_props (.core_clk, .arst_n, .portReq, .portRsp,
  .convertStartPin, .convertStartClockPin, .rawCode, .events);
`default_nettype wire

// ===== test/adccal_fabric.sv
`timescale 1ns/100ps
`default_nettype none
module adccal_fabric (
  // Clock
  input  wire logic                         core_clk,
  // Register port
  output adccal_pkg::adccal_port_req_s      portReq,
  input  wire adccal_pkg::adccal_port_rsp_s portRsp,
  // Convert start
  output logic                              convertStartPin,
  output logic                              convertStartClockPin
);
  import adccal_pkg::*;

  initial begin
    portReq = '0;
    convertStartPin = 1'b0;
    convertStartClockPin = 1'b0;
  end

  // Enable for one cycle, qualifiers held until ready, then scrambled
  task automatic access(input logic we, input logic [6:0] a, input logic [15:0] wd,
                        output logic [15:0] rd);
    int k;
    @(negedge core_clk);
    portReq <= '{1'b1, we, a, wd};
    @(negedge core_clk);
    portReq.enable <= 1'b0;
    for (k = 0; k < 8 && portRsp.ready !== 1'b1; k++) @(negedge core_clk);
    // Answer taken at the edge that samples ready high
    @(posedge core_clk);
    rd = portRsp.rdata;
    @(negedge core_clk);
    portReq <= '{1'b0, 1'b0, ~a, ~wd};
  endtask

  // Two cycles wide so the synchroniser cannot miss it
  task automatic pulse(input logic useClockPin);
    @(negedge core_clk);
    if (useClockPin) convertStartClockPin <= 1'b1;
    else convertStartPin <= 1'b1;
    repeat (2) @(negedge core_clk);
    convertStartPin <= 1'b0;
    convertStartClockPin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import adccal_pkg::*;

  logic             core_clk = 1'b0;
  logic             arst_n = 1'b0;
  logic [9:0]       rawCode = 10'h2a5;
  adccal_port_req_s portReq;
  adccal_port_rsp_s portRsp;
  adccal_events_s   events;
  logic             convertStartPin;
  logic             convertStartClockPin;
  logic [15:0]      rd;
  int               n;
  int               cycles = 0;
  int               failCount = 0;
  int               checkCount = 0;

  always #25 core_clk = ~core_clk;

  adccal_fabric i_fabric (.core_clk, .portReq, .portRsp, .convertStartPin,
    .convertStartClockPin);
  adccal_ctrl i_dut (.core_clk, .arst_n, .portReq, .portRsp, .convertStartPin,
    .convertStartClockPin, .rawCode, .events);

  task automatic check(input string what, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      printVerdict();
    end
  end

  task automatic waitBusy(input logic lvl, output int cnt, input int lim);
    for (cnt = 0; cnt < lim && events.busy !== lvl; cnt++) @(negedge core_clk);
  endtask

  // Config writes are issued while busy is high and take effect at the next busy fall
  task automatic cfg(input logic [6:0] a, input logic [15:0] d);
    waitBusy(1'b1, n, 800);
    i_fabric.access(1'b1, a, d, rd);
  endtask

  task automatic convEnd(input logic [4:0] ch, input logic end_of_sequence);
    waitBusy(1'b1, n, 800);
    waitBusy(1'b0, n, 800);
    check("channel", events.channel, ch);
    repeat (EOC_DELAY) @(negedge core_clk);
    check("end of conversion", events.endOfConv, 1'b1);
    check("end of sequence", events.endOfSequence, end_of_sequence);
    @(negedge core_clk);
    check("end of conversion width", events.endOfConv, 1'b0);
  endtask

  task automatic testRegs();
    logic [15:0] v;
    i_fabric.access(1'b0, ADDR_CONFIG2, 16'h0000, rd);
    check("divider reset", rd, CONFIG2_RESET);
    i_fabric.access(1'b0, 7'h7f, 16'h0000, rd);
    check("unmapped read", rd, 16'h0000);
    for (int a = 8; a < 11; a++) begin
      i_fabric.access(1'b0, 7'(a), 16'h0000, v);
      i_fabric.access(1'b1, 7'(a), ~v, rd);
      i_fabric.access(1'b0, 7'(a), 16'h0000, rd);
      check("coefficient after write", rd, v);
    end
  endtask

  task automatic testContinuous();
    logic [15:0] ratio [2] = '{16'h1000, 16'h0200};
    int          expLen [2] = '{CONV_CYCLES * 16, CONV_CYCLES * MIN_DIV};
    convEnd(5'h00, 1'b0);
    i_fabric.access(1'b0, ADDR_RESULT_BASE, 16'h0000, rd);
    check("uncorrected result", rd[15:6], rawCode);
    waitBusy(1'b1, n, 800);
    waitBusy(1'b0, n, 800);
    check("busy length", n, CONV_CYCLES * MIN_DIV);
    waitBusy(1'b1, n, 800);
    check("acquisition", n >= ACQ_CYCLES * MIN_DIV, 1'b1);
    foreach (ratio[i]) begin
      cfg(ADDR_CONFIG2, ratio[i]);
      waitBusy(1'b0, n, 800);
      waitBusy(1'b1, n, 800);
      waitBusy(1'b0, n, 800);
      check("busy length at ratio", n, expLen[i]);
    end
  endtask

  task automatic testAcqExtend();
    cfg(ADDR_CONFIG0, 16'h0100);
    waitBusy(1'b0, n, 800);
    waitBusy(1'b1, n, 800);
    check("long acquisition", n >= (ACQ_CYCLES + ACQ_EXTRA) * MIN_DIV, 1'b1);
    cfg(ADDR_CONFIG0, 16'h0000);
    waitBusy(1'b0, n, 800);
    waitBusy(1'b1, n, 800);
    check("short acquisition", n < (ACQ_CYCLES + ACQ_EXTRA) * MIN_DIV, 1'b1);
  endtask

  task automatic testCalibration();
    logic [15:0] coef [3];
    logic [9:0]  expCorr;
    cfg(ADDR_CONFIG0, {11'h000, CAL_CHANNEL});
    waitBusy(1'b0, n, 800);
    cfg(ADDR_CONFIG0, 16'h0000);
    convEnd(CAL_CHANNEL, 1'b0);
    for (int i = 0; i < 3; i++) i_fabric.access(1'b0, ADDR_SUPPLY_OFFSET + 7'(i), 16'h0, coef[i]);
    check("gain upper bits", coef[2][15:6], 10'h000);
    rawCode = 10'h1c4;
    convEnd(5'h00, 1'b0);
    for (int i = 0; i < 3; i++) begin
      i_fabric.access(1'b0, ADDR_SUPPLY_OFFSET + 7'(i), 16'h0000, rd);
      check("coefficient kept", rd, coef[i]);
    end
    // Offset removed, then scaled by 1 +/- 0.2 percent per gain count
    expCorr = 10'(((int'(rawCode) - int'($signed(coef[1][15:6])))
                   * (coef[2][5] ? 500 + int'(coef[2][4:0]) : 500 - int'(coef[2][4:0])))
                  / 500);
    cfg(ADDR_CONFIG1, 16'h0030);
    convEnd(5'h00, 1'b0);
    i_fabric.access(1'b0, ADDR_RESULT_BASE, 16'h0000, rd);
    check("corrected result", rd[15:6], expCorr);
  endtask

  task automatic testEvent();
    cfg(ADDR_CONFIG0, 16'h0200);
    waitBusy(1'b0, n, 800);
    waitBusy(1'b1, n, 300);
    check("idle without start", n, 300);
    i_fabric.pulse(1'b0);
    convEnd(5'h00, 1'b0);
    repeat (40) @(negedge core_clk);
    i_fabric.pulse(1'b1);
    cfg(ADDR_CONFIG0, 16'h0000);
    convEnd(5'h00, 1'b0);
    waitBusy(1'b1, n, 400);
    check("continuous again", events.busy, 1'b1);
  endtask

  task automatic testSequence();
    logic [4:0] ch;
    cfg(ADDR_SEQ_SELECT0, 16'h0003);
    cfg(ADDR_CONFIG1, 16'h1000);
    waitBusy(1'b0, n, 800);
    waitBusy(1'b1, n, 800);
    waitBusy(1'b0, n, 800);
    ch = events.channel;
    repeat (3) begin
      ch = ch ^ 5'h01;
      convEnd(ch, ch == 5'h01);
    end
  endtask

  // Sixteen samples per result; two input levels so the mean is visible
  task automatic testAverage();
    cfg(ADDR_CONFIG1, 16'h0000);
    cfg(ADDR_AVERAGE0, 16'h0001);
    waitBusy(1'b0, n, 800);
    rawCode = 10'h100;
    for (int i = 0; i < 16; i++) begin
      waitBusy(1'b1, n, 800);
      waitBusy(1'b0, n, 800);
      repeat (EOC_DELAY) @(negedge core_clk);
      check("averaged pulse", events.endOfConv, i == 15);
      if (i == 7) rawCode = 10'h140;
    end
    i_fabric.access(1'b0, ADDR_RESULT_BASE, 16'h0000, rd);
    check("averaged result", rd[15:6], 10'h120);
  endtask

  initial begin
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    testRegs();
    testContinuous();
    testAcqExtend();
    testCalibration();
    testEvent();
    testSequence();
    testAverage();
    printVerdict();
  end
endmodule
`default_nettype wire
